// [logic/seb_master.v]
// seb_master: two-wire serial bus master with software byte registers
// and an automatic eeprom load after reset; assumes external pullups on
// both lines and a single master on the bus
`include "seb_regs.vh"
`default_nettype none

// Operation
// - clock line toggles near 100 kHz during transfers.
// - pulled-up clock line at reset means eeprom present; only then autoload.
// - data register holds byte to send, or byte received after a read.
// - index register is sent as word address, skipped in quick command.
// - writing target address while idle stores address and direction and starts.
// - control/status shows read-valid, busy, error; holds protocol select.
// - every transfer begins with a start: data falls while clock high.
// - requested transfer ends with a stop: data rises while clock high.
// - data line changes only while clock is low, except start/stop.
// - eight-bit bytes, any number, each followed by an acknowledge bit.
// - receiver acknowledges by holding data low through clock high.
// - sole master; idle bus has clock released and not toggling.
// - doubleword reads come only from the reset-time eeprom load.
// - byte write: start, address with write, index, data MSB first, stop.
// - missing slave acknowledge sets the error status bit.
// - byte read sets direction bit and master acknowledges received bytes.
// - during read data the slave drives data, master drives clock.
// - autoload addresses the eeprom at seven-bit address 1010 000.
// - autoload expects function byte at offset zero, then count 20h.
module seb_master (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] cfgAddr,
  input wire cfgWrEn,
  input wire [7:0] cfgWrData,
  input wire cfgRdEn,
  output wire [7:0] cfgRdData,
  input wire sclIn,
  output wire sclOut,
  output wire sclOeN,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOeN,
  output wire loadValid,
  output wire [7:0] loadIndex,
  output wire [7:0] loadData
);

  localparam [3:0] ST_BOOT = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_ADDR = 4'h3;
  localparam [3:0] ST_INDEX = 4'h4;
  localparam [3:0] ST_RSTART = 4'h5;
  localparam [3:0] ST_ADDR_RD = 4'h6;
  localparam [3:0] ST_DATA_TX = 4'h7;
  localparam [3:0] ST_DATA_RX = 4'h8;
  localparam [3:0] ST_STOP = 4'h9;
  localparam [7:0] LAST_IDX = `SEB_EE_COUNT + 8'h01;

  // pin synchronisers
  reg sclMeta_ff;
  reg sclSync_ff;
  reg sdaMeta_ff;
  reg sdaSync_ff;

  // software-visible registers
  reg [7:0] dataReg_ff;
  reg [7:0] indexReg_ff;
  reg [7:0] targetReg_ff;
  reg quickSel_ff;
  reg rdValid_ff;
  reg busy_ff;
  reg error_ff;
  reg present_ff;
  reg loadErr_ff;
  reg loadDone_ff;
  reg [7:0] rdData_ff;

  // sequencer
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [3:0] bitCnt_ff;
  reg [3:0] nxt_bitCnt;
  reg waitDone_ff;
  reg nxt_waitDone;
  reg autoMode_ff;
  reg [7:0] rxShift_ff;
  reg [7:0] autoIdx_ff;
  reg [3:0] bootCnt_ff;
  reg loadValid_ff;
  reg [7:0] loadIndex_ff;
  reg [7:0] loadData_ff;

  reg [1:0] engCmd;
  reg engBit;
  wire engValid;
  wire engDone;
  wire engRx;
  wire active;
  wire txState;
  wire startSw;
  wire errClr;
  wire [7:0] txByte;
  wire txBit;
  wire rxAck;
  wire byteEnd;
  wire nackSeen;
  wire rxCapture;
  wire errSet;

  // byte shifted out in each transmit state
  function [7:0] txByteSel;
    input [3:0] st;
    input auto;
    input quick;
    input [7:0] target;
    input [7:0] index;
    input [7:0] data;
    begin
      case (st)
        ST_ADDR:
          if (auto)
            txByteSel = {`SEB_EE_ADDR7, 1'b0};
          else if (quick)
            txByteSel = target;
          else
            txByteSel = {target[7:1], 1'b0};
        ST_INDEX:
          txByteSel = auto ? `SEB_EE_WORD0 : index;
        ST_ADDR_RD:
          txByteSel = auto ? {`SEB_EE_ADDR7, 1'b1} : {target[7:1], 1'b1};
        ST_DATA_TX:
          txByteSel = data;
        default:
          txByteSel = 8'h00;
      endcase
    end
  endfunction

  // control/status image
  function [7:0] ctrlImage;
    input rdv;
    input bsy;
    input err;
    input qck;
    input prs;
    input lerr;
    input ldone;
    begin
      ctrlImage = 8'h00;
      ctrlImage[`SEB_CTRL_RDVALID] = rdv;
      ctrlImage[`SEB_CTRL_BUSY] = bsy;
      ctrlImage[`SEB_CTRL_ERROR] = err;
      ctrlImage[`SEB_CTRL_QUICK] = qck;
      ctrlImage[`SEB_CTRL_PRESENT] = prs;
      ctrlImage[`SEB_CTRL_LOADERR] = lerr;
      ctrlImage[`SEB_CTRL_LOADDONE] = ldone;
    end
  endfunction

  // two flops on each line before anything looks at it
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sclMeta_ff <= 1'b1;
      sclSync_ff <= 1'b1;
      sdaMeta_ff <= 1'b1;
      sdaSync_ff <= 1'b1;
    end
    else
    begin
      sclMeta_ff <= sclIn;
      sclSync_ff <= sclMeta_ff;
      sdaMeta_ff <= sdaIn;
      sdaSync_ff <= sdaMeta_ff;
    end
  end

  // a start is only taken when idle so a live transfer is never disturbed
  assign startSw = cfgWrEn && (cfgAddr == `SEB_OFS_TARGET) && !busy_ff
    && (state_ff == ST_IDLE);
  assign errClr = cfgWrEn && (cfgAddr == `SEB_OFS_CTRL)
    && cfgWrData[`SEB_CTRL_ERROR];

  assign active = (state_ff != ST_BOOT) && (state_ff != ST_IDLE);
  assign txState = (state_ff == ST_ADDR) || (state_ff == ST_INDEX)
    || (state_ff == ST_ADDR_RD) || (state_ff == ST_DATA_TX);
  assign engValid = active && !waitDone_ff;
  assign txByte = txByteSel(state_ff, autoMode_ff, quickSel_ff,
    targetReg_ff, indexReg_ff, dataReg_ff);
  assign txBit = txByte[3'h7 - bitCnt_ff[2:0]];
  assign byteEnd = engDone && (bitCnt_ff == 4'h8);
  assign nackSeen = byteEnd && txState && (engRx == `SEB_NACK);
  assign errSet = nackSeen;
  assign rxCapture = byteEnd && (state_ff == ST_DATA_RX);

  // acknowledge sent after a received byte: software reads always ack;
  // the load refuses a bad count and the final byte to end the burst
  assign rxAck = !autoMode_ff ? `SEB_ACK :
    ((autoIdx_ff == 8'h01) && (rxShift_ff != `SEB_EE_COUNT)) ? `SEB_NACK :
    (autoIdx_ff == LAST_IDX) ? `SEB_NACK : `SEB_ACK;

  // command to the bit engine for the current state and bit
  always @*
  begin
    engCmd = `SEB_CMD_STOP;
    engBit = 1'b1;
    case (state_ff)
      ST_START, ST_RSTART:
        engCmd = `SEB_CMD_START;
      ST_STOP:
        engCmd = `SEB_CMD_STOP;
      ST_DATA_RX:
        if (bitCnt_ff == 4'h8)
        begin
          engCmd = `SEB_CMD_WRITE;
          engBit = rxAck;
        end
        else
          engCmd = `SEB_CMD_READ;
      default:
        if (bitCnt_ff == 4'h8)
          engCmd = `SEB_CMD_READ;
        else
        begin
          engCmd = `SEB_CMD_WRITE;
          engBit = txBit;
        end
    endcase
  end

  // byte-level sequencing
  always @*
  begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_waitDone = waitDone_ff;
    if (engValid)
      nxt_waitDone = 1'b1;
    if (engDone)
    begin
      nxt_waitDone = 1'b0;
      nxt_bitCnt = 4'h0;
      case (state_ff)
        ST_START:
          nxt_state = ST_ADDR;
        ST_RSTART:
          nxt_state = ST_ADDR_RD;
        ST_STOP:
          nxt_state = ST_IDLE;
        ST_DATA_RX:
          if (bitCnt_ff != 4'h8)
            nxt_bitCnt = bitCnt_ff + 4'h1;
          else if (rxAck == `SEB_NACK || !autoMode_ff)
            nxt_state = ST_STOP;
        ST_ADDR, ST_INDEX, ST_ADDR_RD, ST_DATA_TX:
          if (bitCnt_ff != 4'h8)
            nxt_bitCnt = bitCnt_ff + 4'h1;
          else if (engRx == `SEB_NACK)
            nxt_state = ST_STOP;
          else if (state_ff == ST_ADDR)
            nxt_state = (quickSel_ff && !autoMode_ff) ? ST_STOP : ST_INDEX;
          else if (state_ff == ST_INDEX)
            nxt_state = (autoMode_ff || targetReg_ff[0]) ? ST_RSTART
              : ST_DATA_TX;
          else if (state_ff == ST_ADDR_RD)
            nxt_state = ST_DATA_RX;
          else
            nxt_state = ST_STOP;
        default:
          nxt_state = state_ff;
      endcase
    end
    if (state_ff == ST_IDLE && startSw)
    begin
      nxt_state = ST_START;
      nxt_bitCnt = 4'h0;
      nxt_waitDone = 1'b0;
    end
    if (state_ff == ST_BOOT && bootCnt_ff == `SEB_BOOT_CYC)
      nxt_state = sclSync_ff ? ST_START : ST_IDLE;
  end

  // registers, status and the load stream
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_ff <= ST_BOOT;
      bitCnt_ff <= 4'h0;
      waitDone_ff <= 1'b0;
      dataReg_ff <= `SEB_RST_BYTE;
      indexReg_ff <= `SEB_RST_BYTE;
      targetReg_ff <= `SEB_RST_BYTE;
      quickSel_ff <= `SEB_RST_BIT;
      rdValid_ff <= 1'b0;
      busy_ff <= 1'b0;
      error_ff <= 1'b0;
      present_ff <= 1'b0;
      loadErr_ff <= 1'b0;
      loadDone_ff <= 1'b0;
      autoMode_ff <= 1'b0;
      rxShift_ff <= 8'h00;
      autoIdx_ff <= 8'h00;
      bootCnt_ff <= 4'h0;
      rdData_ff <= 8'h00;
      loadValid_ff <= 1'b0;
      loadIndex_ff <= 8'h00;
      loadData_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      waitDone_ff <= nxt_waitDone;
      loadValid_ff <= 1'b0;

      // the reset-time load is the only source of doubleword reads
      if (state_ff == ST_BOOT)
      begin
        bootCnt_ff <= bootCnt_ff + 4'h1;
        if (bootCnt_ff == `SEB_BOOT_CYC && sclSync_ff)
        begin
          present_ff <= 1'b1;
          autoMode_ff <= 1'b1;
          busy_ff <= 1'b1;
          autoIdx_ff <= 8'h00;
        end
      end

      // software register writes
      if (cfgWrEn && cfgAddr == `SEB_OFS_DATA)
        dataReg_ff <= cfgWrData;
      if (cfgWrEn && cfgAddr == `SEB_OFS_INDEX)
        indexReg_ff <= cfgWrData;
      if (cfgWrEn && cfgAddr == `SEB_OFS_CTRL)
        quickSel_ff <= cfgWrData[`SEB_CTRL_QUICK];
      if (startSw)
      begin
        targetReg_ff <= cfgWrData;
        busy_ff <= 1'b1;
        rdValid_ff <= 1'b0;
      end

      // a new no-acknowledge wins over a clear in the same cycle
      error_ff <= errSet | (error_ff & ~errClr);

      // received bits shift in MSB first
      if (engDone && state_ff == ST_DATA_RX && bitCnt_ff != 4'h8)
        rxShift_ff <= {rxShift_ff[6:0], engRx};

      if (rxCapture && !autoMode_ff)
      begin
        dataReg_ff <= rxShift_ff;
        rdValid_ff <= 1'b1;
      end

      // load bytes past the two header bytes go out on the stream
      if (rxCapture && autoMode_ff)
      begin
        autoIdx_ff <= autoIdx_ff + 8'h01;
        if (autoIdx_ff >= `SEB_EE_FIRST_DATA)
        begin
          loadValid_ff <= 1'b1;
          loadIndex_ff <= autoIdx_ff;
          loadData_ff <= rxShift_ff;
        end
        if (autoIdx_ff == 8'h01 && rxShift_ff != `SEB_EE_COUNT)
          loadErr_ff <= 1'b1;
        if (autoIdx_ff == LAST_IDX)
          loadDone_ff <= 1'b1;
      end
      if (nackSeen && autoMode_ff)
        loadErr_ff <= 1'b1;

      // busy drops only once the stop has been driven
      if (state_ff == ST_STOP && engDone)
      begin
        busy_ff <= 1'b0;
        autoMode_ff <= 1'b0;
      end

      // register read port, one cycle of latency
      if (cfgRdEn)
      begin
        case (cfgAddr)
          `SEB_OFS_DATA: rdData_ff <= dataReg_ff;
          `SEB_OFS_INDEX: rdData_ff <= indexReg_ff;
          `SEB_OFS_TARGET: rdData_ff <= targetReg_ff;
          `SEB_OFS_CTRL: rdData_ff <= ctrlImage(rdValid_ff, busy_ff,
            error_ff, quickSel_ff, present_ff, loadErr_ff, loadDone_ff);
          default: rdData_ff <= 8'h00;
        endcase
      end
    end
  end

  seb_bit_engine u_bit_engine (
    .ref_clk(ref_clk),
    .rst(rst),
    .cmdValid(engValid),
    .cmd(engCmd),
    .cmdBit(engBit),
    .sdaIn(sdaSync_ff),
    .sclOeN(sclOeN),
    .sdaOeN(sdaOeN),
    .doneValid(engDone),
    .rxBit(engRx)
  );

  // open drain: the pin only ever pulls low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign cfgRdData = rdData_ff;
  assign loadValid = loadValid_ff;
  assign loadIndex = loadIndex_ff;
  assign loadData = loadData_ff;

endmodule

`default_nettype wire

// [common/seb_regs.vh]
// seb_regs.vh: offsets, field positions, reset values and timing counts
// of the two-wire serial bus master; assumes a 100 MHz reference clock
`ifndef SEB_REGS_VH
`define SEB_REGS_VH

// configuration-space byte offsets
`define SEB_OFS_DATA 8'hB0
`define SEB_OFS_INDEX 8'hB1
`define SEB_OFS_TARGET 8'hB2
`define SEB_OFS_CTRL 8'hB3

// control and status field positions
`define SEB_CTRL_RDVALID 0
`define SEB_CTRL_BUSY 1
`define SEB_CTRL_ERROR 2
`define SEB_CTRL_QUICK 3
`define SEB_CTRL_PRESENT 4
`define SEB_CTRL_LOADERR 5
`define SEB_CTRL_LOADDONE 6

// reset values
`define SEB_RST_BYTE 8'h00
`define SEB_RST_BIT 1'b0

// initialisation eeprom
`define SEB_EE_ADDR7 7'h50
`define SEB_EE_WORD0 8'h00
`define SEB_EE_COUNT 8'h20
`define SEB_EE_FIRST_DATA 8'h02

// timing
`define SEB_REF_CLK_NS 10
`define SEB_SCL_PERIOD_NS 10000
`define SEB_QTR_CYC (`SEB_SCL_PERIOD_NS / (`SEB_REF_CLK_NS * 4))
`define SEB_BOOT_CYC 4'h8

// bit engine commands and acknowledge levels
`define SEB_CMD_START 2'h0
`define SEB_CMD_STOP 2'h1
`define SEB_CMD_WRITE 2'h2
`define SEB_CMD_READ 2'h3
`define SEB_ACK 1'b0
`define SEB_NACK 1'b1

`endif

// [logic/seb_bit_engine.v]
// seb_bit_engine: one bus bit (start, stop, write, read) in four quarters
// assumes sdaIn is already synchronised and commands come only when idle
`include "seb_regs.vh"
`default_nettype none

module seb_bit_engine (
  input wire ref_clk,
  input wire rst,
  input wire cmdValid,
  input wire [1:0] cmd,
  input wire cmdBit,
  input wire sdaIn,
  output wire sclOeN,
  output wire sdaOeN,
  output wire doneValid,
  output wire rxBit
);

  localparam [31:0] QTR_W = `SEB_QTR_CYC - 1;
  localparam [7:0] QTR_LAST = QTR_W[7:0];

  reg [7:0] qtrCnt_ff;
  reg [1:0] phase_ff;
  reg [1:0] cmd_ff;
  reg bit_ff;
  reg busy_ff;
  reg sclLow_ff;
  reg sdaLow_ff;
  reg done_ff;
  reg rx_ff;
  wire tick;
  wire [1:0] firstDrive;
  wire [1:0] nextDrive;

  // returns {sclLow, sdaLow} for a command quarter
  function [1:0] driveFor;
    input [1:0] c;
    input [1:0] ph;
    input b;
    input prevScl;
    begin
      case (c)
        `SEB_CMD_START:
          case (ph)
            2'h0: driveFor = {prevScl, 1'b0};
            2'h1: driveFor = 2'b00;
            2'h2: driveFor = 2'b01;
            default: driveFor = 2'b11;
          endcase
        `SEB_CMD_STOP:
          case (ph)
            2'h0: driveFor = 2'b11;
            2'h1: driveFor = 2'b01;
            default: driveFor = 2'b00;
          endcase
        `SEB_CMD_WRITE:
          // data set up while low, held across the high phase
          driveFor = {(ph == 2'h0) || (ph == 2'h3), ~b};
        default:
          driveFor = {(ph == 2'h0) || (ph == 2'h3), 1'b0};
      endcase
    end
  endfunction

  // quarter-period enable: four quarters give one bit near 100 kHz
  assign tick = busy_ff && (qtrCnt_ff == QTR_LAST);
  assign firstDrive = driveFor(cmd, 2'h0, cmdBit, sclLow_ff);
  assign nextDrive = driveFor(cmd_ff, phase_ff + 2'h1, bit_ff, sclLow_ff);

  // quarter sequencing; after a stop both lines stay released
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      qtrCnt_ff <= 8'h00;
      phase_ff <= 2'h0;
      cmd_ff <= `SEB_CMD_STOP;
      bit_ff <= 1'b0;
      busy_ff <= 1'b0;
      sclLow_ff <= 1'b0;
      sdaLow_ff <= 1'b0;
      done_ff <= 1'b0;
      rx_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      if (!busy_ff && cmdValid)
      begin
        busy_ff <= 1'b1;
        cmd_ff <= cmd;
        bit_ff <= cmdBit;
        phase_ff <= 2'h0;
        qtrCnt_ff <= 8'h00;
        sclLow_ff <= firstDrive[1];
        sdaLow_ff <= firstDrive[0];
      end
      else if (busy_ff)
      begin
        qtrCnt_ff <= tick ? 8'h00 : qtrCnt_ff + 8'h01;
        if (tick)
        begin
          // sample at the end of the high phase, in the cycle the clock is pulled low
          if (phase_ff == 2'h2)
            rx_ff <= sdaIn;
          if (phase_ff == 2'h3)
          begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end
          else
          begin
            phase_ff <= phase_ff + 2'h1;
            sclLow_ff <= nextDrive[1];
            sdaLow_ff <= nextDrive[0];
          end
        end
      end
    end
  end

  assign sclOeN = ~sclLow_ff;
  assign sdaOeN = ~sdaLow_ff;
  assign doneValid = done_ff;
  assign rxBit = rx_ff;

endmodule

`default_nettype wire

// [tb/seb_master_props.sv]
// seb_master_props: bus timing and register checks for seb_master
// assumes it is bound to seb_master and sees only that module's ports
`include "seb_regs.vh"
`default_nettype none

module seb_master_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] cfgAddr,
  input wire logic cfgWrEn,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgRdData,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOeN,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  input wire logic loadValid,
  input wire logic [7:0] loadIndex,
  input wire logic [7:0] loadData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] hiCnt_ff;
  logic [15:0] loCnt_ff;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // cycles the clock line has been released or pulled; the high count
  // saturates so that a long idle bus reads as a large value
  always_ff @(posedge ref_clk)
  begin
    if (rst || !sclOeN)
      hiCnt_ff <= 16'h0000;
    else if (hiCnt_ff != 16'hFFFF)
      hiCnt_ff <= hiCnt_ff + 16'h0001;
    if (rst || sclOeN)
      loCnt_ff <= 16'h0000;
    else
      loCnt_ff <= loCnt_ff + 16'h0001;
  end

  a_scl_high_time: assert property (
    $fell(sclOeN) && hiCnt_ff < 16'd1100 |-> hiCnt_ff inside {[498:502]})
    else $error("clock high time off");
  a_scl_low_time: assert property (
    $rose(sclOeN) |-> loCnt_ff inside {[498:506]})
    else $error("clock low time off");
  a_scl_no_stall: assert property (
    !sclOeN |-> loCnt_ff < 16'd510)
    else $error("clock held low too long");
  a_sda_high_window: assert property (
    $changed(sdaOeN) && sclOeN && $past(sclOeN)
    |-> hiCnt_ff inside {[248:252]} || hiCnt_ff > 16'd1100)
    else $error("data moved during clock high");
  a_start_on_write: assert property (
    cfgWrEn && cfgAddr == `SEB_OFS_TARGET && hiCnt_ff > 16'd1100
    |=> ##[490:515] !sdaOeN && sclOeN)
    else $error("no start after target write");
  a_idle_released: assert property (
    cfgRdEn && cfgAddr == `SEB_OFS_CTRL ##1 !cfgRdData[`SEB_CTRL_BUSY]
    |-> sclOeN && sdaOeN)
    else $error("lines driven while not busy");
  a_data_readback: assert property (
    cfgWrEn && (cfgAddr == `SEB_OFS_DATA || cfgAddr == `SEB_OFS_INDEX)
    ##2 cfgRdEn && !cfgWrEn && cfgAddr == $past(cfgAddr, 2)
    |=> cfgRdData == $past(cfgWrData, 3))
    else $error("byte register readback wrong");
  a_unmapped_zero: assert property (
    cfgRdEn && !(cfgAddr inside {[8'hB0:8'hB3]}) |=> cfgRdData == 8'h00)
    else $error("unmapped read not zero");
  a_open_drain: assert property (
    !sclOut && !sdaOut)
    else $error("line driven high");
  a_load_index: assert property (
    loadValid |-> loadIndex inside {[8'h02:8'h21]})
    else $error("load index out of range");

  c_start: cover property ($fell(sdaOeN) && sclOeN);
  c_stop: cover property ($rose(sdaOeN) && sclOeN);
  c_busy_read: cover property (cfgRdEn ##1 cfgRdData[`SEB_CTRL_BUSY]);
endmodule

bind seb_master seb_master_props chk_u (
  .ref_clk(ref_clk), .rst(rst), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn),
  .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData),
  .sclIn(sclIn), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOeN(sdaOeN), .loadValid(loadValid),
  .loadIndex(loadIndex), .loadData(loadData));

`default_nettype wire

// [tb/seb_slave_model.sv]
// seb_slave_model: behavioural two-wire slave with a 256-byte memory
// assumes pulled-up wires whose levels the bench resolves
`default_nettype none

module seb_slave_model #(parameter logic [6:0] ADDR7 = 7'h3A) (
  input wire logic scl,
  input wire logic sda,
  input wire logic holdScl,
  output logic sclOeN,
  output logic sdaOeN,
  output logic masterAck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:255];
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic [1:0] byteN = 2'h0;
  logic act = 1'b0, tx = 1'b0, hit = 1'b0, ackNow = 1'b0, mSlot = 1'b0;
  // holding the clock low through boot tells the master no eeprom is fitted
  assign sclOeN = !holdScl;
  initial
  begin
    sdaOeN = 1'b1;
    masterAck = 1'b1;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
  end
  // start or repeated start: data falls while clock high
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      act = 1'b1;
      cnt = 4'h0;
      byteN = 2'h0;
      tx = 1'b0;
    end
  // stop: data rises while clock high
  always @(posedge sda)
    if (scl === 1'b1)
      act = 1'b0;
  // bits taken on the rising clock, eight data then one acknowledge
  always @(posedge scl)
    if (act)
    begin
      if (cnt == 4'h8)
      begin
        cnt = 4'h0;
        if (mSlot)
        begin
          masterAck = sda;
          ptr = ptr + 8'h01;
        end
      end
      else
      begin
        sh = {sh[6:0], sda};
        cnt = cnt + 4'h1;
        if (cnt == 4'h8)
        begin
          mSlot = tx;
          if (byteN == 2'h0)
          begin
            hit = sh[7:1] == ADDR7;
            tx = hit && sh[0];
          end
          else if (hit && !tx && byteN == 2'h1)
            ptr = sh;
          else if (hit && !tx)
            mem[ptr] = sh;
          ackNow = hit && !mSlot;
          if (byteN != 2'h3)
            byteN = byteN + 2'h1;
        end
      end
    end
  // the slave moves the data line only while the clock is low
  always @(negedge scl)
    if (!act)
      sdaOeN = 1'b1;
    else if (cnt == 4'h8)
      sdaOeN = !ackNow;
    else if (tx)
      sdaOeN = mem[ptr][3'h7 - cnt[2:0]];
    else
      sdaOeN = 1'b1;
endmodule

`default_nettype wire

// [tb/seb_master_tb.sv]
// seb_master_tb: byte write, byte read and a refused quick command
// assumes seb_master, its checker and the slave model are compiled first
`include "seb_regs.vh"
`default_nettype none

module seb_master_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic holdScl = 1'b1;
  logic cfgWrEn = 1'b0;
  logic cfgRdEn = 1'b0;
  logic [7:0] cfgAddr = 8'h00;
  logic [7:0] cfgWrData = 8'h00;
  logic [7:0] cfgRdData, loadIndex, loadData, rdVal;
  logic sclOut, sdaOut, sclOeN, sdaOeN, loadValid;
  logic sSclOeN, sSdaOeN, masterAck, eeSdaOeN;
  logic sawLoad = 1'b0;
  int errors = 0;
  int n_tests = 0;
  // pulled-up wires: low only while some party pulls them
  wire scl = (sclOeN !== 1'b0) && (sSclOeN !== 1'b0);
  wire sda = (sdaOeN !== 1'b0) && (sSdaOeN !== 1'b0)
    && (eeSdaOeN !== 1'b0);

  seb_master dut_u (
    .ref_clk(ref_clk), .rst(rst), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn),
    .cfgWrData(cfgWrData), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData),
    .sclIn(scl), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .loadValid(loadValid),
    .loadIndex(loadIndex), .loadData(loadData));
  seb_slave_model #(.ADDR7(7'h3A)) slv_u (.scl(scl), .sda(sda),
    .holdScl(holdScl), .sclOeN(sSclOeN), .sdaOeN(sSdaOeN),
    .masterAck(masterAck));
  // the init eeprom sits at its fixed bus address and never holds the clock
  seb_slave_model #(.ADDR7(`SEB_EE_ADDR7)) ee_u (.scl(scl), .sda(sda),
    .holdScl(1'b0), .sclOeN(), .sdaOeN(eeSdaOeN), .masterAck());

  always #5 ref_clk = ~ref_clk;
  // any load byte at all means the absent-eeprom path was not taken
  always @(posedge ref_clk)
    if (loadValid === 1'b1)
      sawLoad <= 1'b1;

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s: got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    cfgAddr = a;
    cfgWrData = d;
    cfgWrEn = 1'b1;
    @(posedge ref_clk);
    #1;
    cfgWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    cfgAddr = a;
    cfgRdEn = 1'b1;
    @(posedge ref_clk);
    #1;
    cfgRdEn = 1'b0;
    d = cfgRdData;
  endtask
  task automatic rdChk(input logic [7:0] a, exp, input string msg);
    rd(a, rdVal);
    chk(rdVal, exp, msg);
  endtask
  // a quiet bus before each start keeps the start timing unambiguous
  task automatic launch(input logic [7:0] t);
    repeat (1200) @(posedge ref_clk);
    wr(`SEB_OFS_TARGET, t);
  endtask
  // poll busy; a bus byte takes about 9000 cycles
  task automatic waitIdle();
    for (int i = 0; i < 600; i++)
    begin
      repeat (100) @(posedge ref_clk);
      rd(`SEB_OFS_CTRL, rdVal);
      if (rdVal[`SEB_CTRL_BUSY] === 1'b0)
        return;
    end
    chk(8'h01, 8'h00, "busy stuck");
  endtask

  // watchdog: the sequence needs roughly 85000 cycles
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    conclude();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (30) @(posedge ref_clk);
    #1;
    holdScl = 1'b0;
    slv_u.mem[9] = 8'h6E;
    slv_u.mem[10] = 8'hFF;
    rdChk(`SEB_OFS_CTRL, 8'h00, "status after boot");
    rdChk(8'hB4, 8'h00, "unmapped read");
    // each readback follows its write directly, so the checker sees it
    wr(`SEB_OFS_DATA, 8'hA5);
    rdChk(`SEB_OFS_DATA, 8'hA5, "data readback");
    wr(`SEB_OFS_INDEX, 8'h05);
    rdChk(`SEB_OFS_INDEX, 8'h05, "index readback");
    // byte write, with a second target write dropped while busy
    launch(8'h74);
    rdChk(`SEB_OFS_CTRL, 8'h02, "busy on start");
    wr(`SEB_OFS_TARGET, 8'h55);
    rdChk(`SEB_OFS_TARGET, 8'h74, "target kept");
    waitIdle();
    rdChk(`SEB_OFS_CTRL, 8'h00, "write status");
    chk(slv_u.mem[5], 8'hA5, "slave byte");
    chk({6'h00, sclOeN, sdaOeN}, 8'h03, "idle lines");
    // byte read from word 09h
    wr(`SEB_OFS_INDEX, 8'h09);
    wr(`SEB_OFS_DATA, 8'h00);
    launch(8'h75);
    waitIdle();
    rdChk(`SEB_OFS_CTRL, 8'h01, "read valid");
    rdChk(`SEB_OFS_DATA, 8'h6E, "read byte");
    chk({7'h00, masterAck}, 8'h00, "master ack");
    // quick command to an absent slave: no acknowledge
    wr(`SEB_OFS_CTRL, 8'h08);
    launch(8'h22);
    waitIdle();
    rdChk(`SEB_OFS_CTRL, 8'h0C, "nack error");
    wr(`SEB_OFS_CTRL, 8'h04);
    rdChk(`SEB_OFS_CTRL, 8'h00, "error cleared");
    chk({7'h00, sawLoad}, 8'h00, "load ran");
    chk(loadIndex | loadData, 8'h00, "load stream idle");
    // second reset with the clock line free: the eeprom is seen and the
    // load owns the bus; the run ends long before its first start edge
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    repeat (12) @(posedge ref_clk);
    rdChk(`SEB_OFS_CTRL, 8'h12, "eeprom seen");
    wr(`SEB_OFS_TARGET, 8'h74);
    rdChk(`SEB_OFS_TARGET, 8'h00, "load undisturbed");
    conclude();
  end
endmodule

`default_nettype wire
